// file: rtl/ppc_pkg.sv
/*
 * ppc_pkg: shared constants and types for the port pin configuration block.
 * Assumes a byte-wide register map reached over classic Wishbone, word aligned.
 */
package ppc_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_S_PULL_POL   = 8'h0d;
    localparam logic [7:0] IDX_S_OD_SEL     = 8'h0e;
    localparam logic [7:0] IDX_M_DATA       = 8'h10;
    localparam logic [7:0] IDX_M_PIN_LEVEL  = 8'h11;
    localparam logic [7:0] IDX_M_DIRECTION  = 8'h12;
    localparam logic [7:0] IDX_M_DRV_RED    = 8'h13;
    localparam logic [7:0] IDX_S_PULL_EN    = 8'h14;
    localparam logic [7:0] IDX_M_PERIPH_OVR = 8'h15;
    localparam int         ADDR_W           = 8;
    localparam int         S_W              = 4;
    localparam int         M_W              = 6;
    localparam int         SPI_LO           = 2;
    localparam logic [S_W-1:0] S_PULL_EN_RST = 4'hf;
    localparam logic [S_W-1:0] S_ZERO_RST    = 4'h0;
    localparam logic [M_W-1:0] M_ZERO_RST    = 6'h00;
    localparam int         SYNC_STAGES      = 2;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

    // per-pin direction resolution result for port m
    typedef struct packed {
        logic [M_W-1:0] is_out;
    } ppc_dir_t;
endpackage

// file: rtl/ppc_dir_if.sv
/*
 * ppc_dir_if: carries peripheral ownership and the resolved port m direction
 * between the top and the direction resolver.
 */
`timescale 1ns/1ps
interface ppc_dir_if;
    import ppc_pkg::*;
    logic [M_W-1:0] dir_bits;
    logic [M_W-1:0] force_out;
    logic [M_W-1:0] force_in;
    logic [M_W-1:0] is_out;
    modport top (output dir_bits, output force_out, output force_in, input is_out);
    modport res (input dir_bits, input force_out, input force_in, output is_out);
endinterface

// file: rtl/ppc_dir_resolve.sv
/*
 * ppc_dir_resolve: combines direction register with peripheral overrides.
 * Assumes the override inputs are already on the bus clock.
 */
`timescale 1ns/1ps
module ppc_dir_resolve (
    ppc_dir_if.res d
);
    import ppc_pkg::*;
    // transmit ownership wins over receive; the direction bit counts only when free
    genvar g;
    generate
        for (g = 0; g < M_W; g++) begin : g_pin
            assign d.is_out[g] = d.force_out[g] ? 1'b1 :
                                 d.force_in[g]  ? 1'b0 : d.dir_bits[g];
        end
    endgenerate
endmodule

// file: rtl/ppc_sync.sv
/*
 * ppc_sync: two-stage synchroniser for pin levels.
 * Assumes the pins are asynchronous to CLOCK_I.
 */
`timescale 1ns/1ps
module ppc_sync #(
    parameter int W = 6
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    import ppc_pkg::*;
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ppc_sync_t;
    ppc_sync_t st_reg;
    ppc_sync_t st_next;

    // first stage only feeds the second
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = d_i;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.s2;
endmodule

// file: rtl/ppc_top.sv
/*
 * ppc_top: pin configuration and data logic for port s (pull, open drain)
 * and port m (latch, readback, direction, reduced drive).
 * Assumes a classic Wishbone master on CLOCK_I and pad cells outside that
 * take the output enables, pull controls and drive selects.
 */
`timescale 1ns/1ps
// How it works
// - port s polarity 0 selects pull-up on enabled input or open-drain pin
// - port s polarity 1 selects pull-down only on an enabled input pin
// - port s open-drain bit 1 drives low only; 0 means push-pull
// - port s open-drain bit has no effect on input pins
// - port m data read gives latch for outputs, pin level for inputs
// - port m pin-level read always gives synchronised pin states
// - writes to port m pin-level register are ignored
// - port m direction bit 0 means input, 1 output, bits 5..0
// - enabled transmit owner forces output, receive owner forces input unless spi drives that pin out
// - disabled owner hands direction back to the direction bit
// - enabled spi module sets directions of its pins 5..2 not taken by a transmit owner
// - pin reads lag direction changes by up to three cycles
// - port m reduced-drive bit 1 selects about one-third strength
// - reduced-drive bit ignored on pins used as inputs
// - port s pull enables act on inputs or open-drain only, reset on
module ppc_top
    import ppc_pkg::*;
(
    // clock and reset
    input  wire logic                 CLOCK_I,
    input  wire logic                 RST_I,
    // wishbone slave
    input  wire logic                 CYC_I,
    input  wire logic                 STB_I,
    input  wire logic                 WE_I,
    input  wire logic [31:0]          ADR_I,
    input  wire logic [3:0]           SEL_I,
    input  wire logic [31:0]          DAT_I,
    output logic      [31:0]          DAT_O,
    output logic                      ACK_O,
    // port s pins (direction and data owned elsewhere)
    input  wire logic [ppc_pkg::S_W-1:0] S_DIR_I,
    input  wire logic [ppc_pkg::S_W-1:0] S_OUT_VAL_I,
    output logic      [ppc_pkg::S_W-1:0] S_PIN_OE_O,
    output logic      [ppc_pkg::S_W-1:0] S_PIN_O,
    output logic      [ppc_pkg::S_W-1:0] S_PULL_UP_O,
    output logic      [ppc_pkg::S_W-1:0] S_PULL_DOWN_O,
    // port m pins
    input  wire logic [ppc_pkg::M_W-1:0] M_PIN_I,
    output logic      [ppc_pkg::M_W-1:0] M_PIN_O,
    output logic      [ppc_pkg::M_W-1:0] M_PIN_OE_O,
    output logic      [ppc_pkg::M_W-1:0] M_DRIVE_REDUCED_O,
    // peripheral ownership of port m pins, same clock
    input  wire logic [ppc_pkg::M_W-1:0] M_PERIPH_TX_EN_I,
    input  wire logic [ppc_pkg::M_W-1:0] M_PERIPH_RX_EN_I,
    input  wire logic [ppc_pkg::M_W-1:0] M_PERIPH_OUT_I,
    input  wire logic                    SPI_EN_I,
    input  wire logic [ppc_pkg::M_W-1:0] SPI_DIR_I
);
    import ppc_pkg::*;

    typedef struct packed {
        logic [S_W-1:0] s_pull_polarity;
        logic [S_W-1:0] s_open_drain_select;
        logic [S_W-1:0] s_pull_enable;
        logic [M_W-1:0] m_output_latch;
        logic [M_W-1:0] m_direction;
        logic [M_W-1:0] m_drive_reduce;
        logic [31:0]    dat;
        logic           ack;
        logic [S_W-1:0] s_oe;
        logic [S_W-1:0] s_out;
        logic [S_W-1:0] s_pu;
        logic [S_W-1:0] s_pd;
        logic [M_W-1:0] m_oe;
        logic [M_W-1:0] m_out;
        logic [M_W-1:0] m_red;
    } ppc_state_t;

    ppc_state_t     st_reg;
    ppc_state_t     st_next;
    logic [M_W-1:0] m_pin_level;
    logic [M_W-1:0] m_force_out;
    logic [M_W-1:0] m_force_in;
    logic [M_W-1:0] m_is_out;
    logic [M_W-1:0] m_spi_pins;
    logic [ADDR_W-1:0] idx;
    logic           bus_req;

    ppc_dir_if dir_bus ();

    // pin levels cross into the bus clock before anyone reads them
    ppc_sync #(
        .W (M_W)
    ) u_sync (
        .clk_i (CLOCK_I),
        .rst_i (RST_I),
        .d_i   (M_PIN_I),
        .q_o   (m_pin_level)
    );

    // spi claims only pins 5..2; its direction replaces the register there
    always_comb begin
        m_spi_pins = '0;
        m_spi_pins[M_W-1:SPI_LO] = {(M_W-SPI_LO){SPI_EN_I}};
        m_force_out = M_PERIPH_TX_EN_I | (m_spi_pins & SPI_DIR_I);
        m_force_in  = (M_PERIPH_RX_EN_I & ~M_PERIPH_TX_EN_I)
                    | (m_spi_pins & ~SPI_DIR_I);
    end

    assign dir_bus.dir_bits  = st_reg.m_direction;
    assign dir_bus.force_out = m_force_out;
    assign dir_bus.force_in  = m_force_in;
    assign m_is_out          = dir_bus.is_out;

    ppc_dir_resolve u_dir (
        .d (dir_bus.res)
    );

    assign idx     = ADR_I[ADDR_W+1:2];
    assign bus_req = CYC_I & STB_I & ~st_reg.ack;

    // register file, bus answer and pad controls, all registered
    always_comb begin
        st_next     = st_reg;
        st_next.ack = bus_req;
        // writes take the low byte lane only; narrow registers ignore upper bits
        if (bus_req && WE_I && SEL_I[0] && ADR_I[31:ADDR_W+2] == '0) begin
            case (idx)
                IDX_S_PULL_POL:  st_next.s_pull_polarity     = DAT_I[S_W-1:0];
                IDX_S_OD_SEL:    st_next.s_open_drain_select = DAT_I[S_W-1:0];
                IDX_S_PULL_EN:   st_next.s_pull_enable       = DAT_I[S_W-1:0];
                IDX_M_DATA:      st_next.m_output_latch      = DAT_I[M_W-1:0];
                IDX_M_DIRECTION: st_next.m_direction         = DAT_I[M_W-1:0];
                IDX_M_DRV_RED:   st_next.m_drive_reduce      = DAT_I[M_W-1:0];
                IDX_M_PIN_LEVEL: st_next.m_drive_reduce      = st_reg.m_drive_reduce;
                default:         st_next.dat                 = st_reg.dat;
            endcase
        end
        // read data; unmapped addresses answer with zero
        st_next.dat = UNMAPPED_DATA;
        if (bus_req && !WE_I && ADR_I[31:ADDR_W+2] == '0) begin
            case (idx)
                IDX_S_PULL_POL:   st_next.dat[S_W-1:0] = st_reg.s_pull_polarity;
                IDX_S_OD_SEL:     st_next.dat[S_W-1:0] = st_reg.s_open_drain_select;
                IDX_S_PULL_EN:    st_next.dat[S_W-1:0] = st_reg.s_pull_enable;
                IDX_M_DATA:       st_next.dat[M_W-1:0] = (m_is_out & st_reg.m_output_latch)
                                                       | (~m_is_out & m_pin_level);
                IDX_M_PIN_LEVEL:  st_next.dat[M_W-1:0] = m_pin_level;
                IDX_M_DIRECTION:  st_next.dat[M_W-1:0] = st_reg.m_direction;
                IDX_M_DRV_RED:    st_next.dat[M_W-1:0] = st_reg.m_drive_reduce;
                IDX_M_PERIPH_OVR: st_next.dat[M_W-1:0] = m_force_out | m_force_in;
                default:          st_next.dat          = UNMAPPED_DATA;
            endcase
        end
        // port s: open drain only drives lows; inputs never drive
        for (int i = 0; i < S_W; i++) begin
            if (!S_DIR_I[i]) begin
                st_next.s_oe[i] = 1'b0;
            end else if (st_reg.s_open_drain_select[i]) begin
                st_next.s_oe[i] = ~S_OUT_VAL_I[i];
            end else begin
                st_next.s_oe[i] = 1'b1;
            end
            st_next.s_out[i] = S_OUT_VAL_I[i] & ~st_reg.s_open_drain_select[i];
            // pulls stay off on push-pull outputs so they never fight the driver
            st_next.s_pu[i] = st_reg.s_pull_enable[i] & ~st_reg.s_pull_polarity[i]
                            & (~S_DIR_I[i] | st_reg.s_open_drain_select[i]);
            st_next.s_pd[i] = st_reg.s_pull_enable[i] & st_reg.s_pull_polarity[i]
                            & ~S_DIR_I[i];
        end
        // port m: peripheral data rides out while it owns the pin
        st_next.m_oe  = m_is_out;
        st_next.m_out = (m_force_out & M_PERIPH_OUT_I) | (~m_force_out & st_reg.m_output_latch);
        st_next.m_red = st_reg.m_drive_reduce & m_is_out;
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            st_reg                     <= '0;
            st_reg.s_pull_enable       <= S_PULL_EN_RST;
            st_reg.s_pull_polarity     <= S_ZERO_RST;
            st_reg.s_open_drain_select <= S_ZERO_RST;
            st_reg.m_direction         <= M_ZERO_RST;
            st_reg.m_drive_reduce      <= M_ZERO_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // every output straight from the state register
    assign DAT_O             = st_reg.dat;
    assign ACK_O             = st_reg.ack;
    assign S_PIN_OE_O        = st_reg.s_oe;
    assign S_PIN_O           = st_reg.s_out;
    assign S_PULL_UP_O       = st_reg.s_pu;
    assign S_PULL_DOWN_O     = st_reg.s_pd;
    assign M_PIN_O           = st_reg.m_out;
    assign M_PIN_OE_O        = st_reg.m_oe;
    assign M_DRIVE_REDUCED_O = st_reg.m_red;
endmodule

// file: tb/ppc_top_props.sv
/* ppc_top_props: port-level checks on ppc_top.
   Assumes only the top ports are visible; bound at the foot. */
`timescale 1ns/1ps
module ppc_top_props
    import ppc_pkg::*;
(
    // clock, reset, bus
    input wire logic           CLOCK_I,
    input wire logic           RST_I,
    input wire logic           CYC_I,
    input wire logic           STB_I,
    input wire logic           ACK_O,
    // port s
    input wire logic [S_W-1:0] S_DIR_I,
    input wire logic [S_W-1:0] S_PIN_OE_O,
    input wire logic [S_W-1:0] S_PULL_UP_O,
    input wire logic [S_W-1:0] S_PULL_DOWN_O,
    // port m
    input wire logic [M_W-1:0] M_PIN_OE_O,
    input wire logic [M_W-1:0] M_DRIVE_REDUCED_O,
    input wire logic [M_W-1:0] M_PERIPH_TX_EN_I,
    input wire logic [M_W-1:0] M_PERIPH_RX_EN_I,
    input wire logic           SPI_EN_I,
    input wire logic [M_W-1:0] SPI_DIR_I
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // a taken request, and two clean cycles since reset so $past is trustworthy
    sequence req_s; CYC_I && STB_I && !ACK_O; endsequence
    sequence run_s; !$past(RST_I) && !$past(RST_I, 2); endsequence
    ack_answer_a: assert property (req_s |=> ACK_O) else $error("no ack after request");
    ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
    ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I)) else $error("ack without request");
    pull_excl_a: assert property ((S_PULL_UP_O & S_PULL_DOWN_O) == 0) else $error("both pulls on");
    pd_input_a: assert property (run_s |-> (S_PULL_DOWN_O & $past(S_DIR_I)) == 0)
        else $error("pull-down on output");
    s_oe_dir_a: assert property (run_s |-> (S_PIN_OE_O & ~$past(S_DIR_I)) == 0)
        else $error("input pin driven");
    rd_input_a: assert property ((M_DRIVE_REDUCED_O & ~M_PIN_OE_O) == 0) else $error("reduced on input");
    tx_force_a: assert property (run_s |-> ($past(M_PERIPH_TX_EN_I) & ~M_PIN_OE_O) == 0)
        else $error("tx pin not output");
    rx_force_a: assert property (run_s |-> ($past(M_PERIPH_RX_EN_I & ~M_PERIPH_TX_EN_I) & M_PIN_OE_O) == 0)
        else $error("rx pin not input");
    spi_dir_a: assert property (run_s and $past(SPI_EN_I && (M_PERIPH_TX_EN_I | M_PERIPH_RX_EN_I) == 0)
        |-> M_PIN_OE_O[5:2] == $past(SPI_DIR_I[5:2])) else $error("spi direction ignored");
    rst_quiet_a: assert property (disable iff (1'b0) RST_I |-> !ACK_O && M_PIN_OE_O == 0 && S_PIN_OE_O == 0)
        else $error("outputs active in reset");
endmodule
bind ppc_top ppc_top_props u_props (.CLOCK_I, .RST_I, .CYC_I, .STB_I, .ACK_O, .S_DIR_I, .S_PIN_OE_O,
    .S_PULL_UP_O, .S_PULL_DOWN_O, .M_PIN_OE_O, .M_DRIVE_REDUCED_O, .M_PERIPH_TX_EN_I, .M_PERIPH_RX_EN_I,
    .SPI_EN_I, .SPI_DIR_I);

// file: tb/ppc_pin_model.sv
/* ppc_pin_model: port m pads with an outside driver behind them.
   Assumes the bench supplies the level seen on undriven pins. */
`timescale 1ns/1ps
module ppc_pin_model
    import ppc_pkg::*;
(
    // pad side of the block
    input  wire logic [M_W-1:0] pin_o_i,
    input  wire logic [M_W-1:0] pin_oe_i,
    // outside world
    input  wire logic [M_W-1:0] ext_i,
    output logic      [M_W-1:0] pin_i_o
);
    // a driven pad shows the block's value; a released one the outside level, not a stale copy
    assign pin_i_o = (pin_o_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule

// file: tb/ppc_top_tb.sv
/* ppc_top_tb: random and corner tests of ppc_top over Wishbone and the pins.
   Assumes the pin model and the bound checker are compiled before it. */
`timescale 1ns/1ps
module ppc_top_tb;
    import ppc_pkg::*;
    logic CLOCK_I = 0, RST_I = 0, CYC_I = 0, STB_I = 0, WE_I = 0, SPI_EN_I = 0, ACK_O;
    logic [31:0] ADR_I = 0, DAT_I = 0, DAT_O, rd;
    logic [3:0] SEL_I = 0, S_DIR_I = 0, S_OUT_VAL_I = 0, S_PIN_OE_O, S_PIN_O, S_PULL_UP_O, S_PULL_DOWN_O, soe;
    logic [M_W-1:0] M_PIN_I, M_PIN_O, M_PIN_OE_O, M_DRIVE_REDUCED_O, o, own, pin;
    logic [M_W-1:0] tx = 0, rx = 0, pout = 0, spid = 0, ext = 0;
    logic [7:0] pol, od, pe, dir, lat, rdr;
    logic [63:0] r;
    int num_errors = 0, tests_run = 0;
    ppc_top dut (.CLOCK_I, .RST_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O,
        .S_DIR_I, .S_OUT_VAL_I, .S_PIN_OE_O, .S_PIN_O, .S_PULL_UP_O, .S_PULL_DOWN_O, .M_PIN_I, .M_PIN_O,
        .M_PIN_OE_O, .M_DRIVE_REDUCED_O, .M_PERIPH_TX_EN_I(tx), .M_PERIPH_RX_EN_I(rx),
        .M_PERIPH_OUT_I(pout), .SPI_EN_I, .SPI_DIR_I(spid));
    ppc_pin_model pins (.pin_o_i(M_PIN_O), .pin_oe_i(M_PIN_OE_O), .ext_i(ext), .pin_i_o(M_PIN_I));
    always #20 CLOCK_I = ~CLOCK_I;
    // one compare, counted
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // classic single cycle; waits for ack under a bound, then one idle cycle
    task automatic bus(logic we, logic [7:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLOCK_I);
        {CYC_I, STB_I, WE_I, SEL_I, ADR_I, DAT_I} <= {2'b11, we, 4'hf, 24'h0, a, 24'h0, d};
        // look between edges so the registered ack is settled, then release at the edge that samples it
        do begin
            @(negedge CLOCK_I);
            n++;
        end while (ACK_O !== 1'b1 && n < 20);
        rd = DAT_O;
        if (n >= 20) chk("ack wait", 0, 1);
        @(posedge CLOCK_I);
        {CYC_I, STB_I, WE_I} <= 3'b000;
        @(posedge CLOCK_I);
    endtask
    // reset values, then an unmapped read
    task automatic rst_chk();
        logic [7:0] a [5] = '{8'h34, 8'h38, 8'h48, 8'h4c, 8'h50};
        for (int i = 0; i < 5; i++) begin
            bus(0, a[i], 0);
            chk("reset value", rd, (i == 4) ? 32'hf : 32'h0);
        end
        bus(0, 8'h7c, 0);
        chk("unmapped read", rd, 0);
    endtask
    // spi takes pins 5..2; transmit beats receive, receive beats the direction bit
    function automatic logic [M_W-1:0] exp_out(logic [M_W-1:0] d);
        return tx | (~rx & (SPI_EN_I ? {spid[5:2], d[1:0]} : d));
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] wa [6] = '{8'h34, 8'h38, 8'h50, 8'h48, 8'h40, 8'h4c};
        logic [7:0] wv [6];
        void'($urandom(32'h33ced3fb));
        // a real rising edge on reset so the asynchronous branch runs before the first clock
        RST_I <= 1;
        repeat (2) @(posedge CLOCK_I);
        RST_I <= 0;
        rst_chk();
        for (int it = 0; it < 40; it++) begin
            r = {$urandom, $urandom};
            if (it == 0) r = '1;
            {pol, od, pe, dir, lat, rdr} = r[47:0];
            {S_DIR_I, S_OUT_VAL_I, ext, pout, spid, SPI_EN_I} <= r[26:0];
            tx <= r[32:27] & (r[0] ? 6'h03 : 6'h3f) & {6{r[40]}};
            rx <= r[38:33] & (r[0] ? 6'h03 : 6'h3f) & {6{r[41]}};
            wv = '{pol, od, pe, dir, lat, rdr};
            for (int k = 0; k < 6; k++) bus(1, wa[k], wv[k]);
            // pin reads lag by two synchroniser stages plus a bus cycle
            repeat (4) @(posedge CLOCK_I);
            o = exp_out(dir[5:0]);
            own = tx | rx | (SPI_EN_I ? 6'h3c : 6'h00);
            pin = (lat[5:0] & o) | (ext & ~o);
            soe = S_DIR_I & ~(od[3:0] & S_OUT_VAL_I);
            chk("m oe", M_PIN_OE_O, o);
            chk("m drive", M_DRIVE_REDUCED_O, rdr[5:0] & o);
            chk("m out", M_PIN_O & o & ~own, lat[5:0] & o & ~own);
            chk("s oe", S_PIN_OE_O, soe);
            chk("s out", S_PIN_O & soe, ~od[3:0] & S_OUT_VAL_I & soe);
            chk("s pull up", S_PULL_UP_O, pe[3:0] & ~pol[3:0] & (~S_DIR_I | od[3:0]));
            chk("s pull down", S_PULL_DOWN_O, pe[3:0] & pol[3:0] & ~S_DIR_I);
            bus(0, 8'h40, 0);
            chk("m data", {rd[31:6], rd[5:0] & ~own}, {26'h0, pin & ~own});
            bus(1, 8'h44, {2'b00, ~pin});
            bus(0, 8'h44, 0);
            chk("m level", {rd[31:6], rd[5:0] & ~(o & own)}, {26'h0, pin & ~(o & own)});
            bus(0, 8'h54, 0);
            chk("m owned", rd, {26'h0, own});
        end
        // second reset in mid-run
        RST_I <= 1;
        repeat (2) @(posedge CLOCK_I);
        RST_I <= 0;
        rst_chk();
        results();
    end
    // watchdog: the sequence needs about two thousand cycles
    initial begin
        #(40 * 30000);
        num_errors++;
        results();
    end
endmodule
